// ===== core/async_static_mem_ctrl.sv
// async static memory controller, region zero only
`timescale 1ns/1ps
`default_nettype none
`include "static_mem_regs.svh"
module async_static_mem_ctrl
    import static_mem_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        req_valid,
    input  wire mem_req_t    req,
    output logic             req_ready,
    output logic             rsp_valid,
    output logic             rsp_error,
    output logic [31:0]      rsp_rdata,
    input  wire region_cfg_t cfg,
    input  wire timing_t     rd_timing,
    input  wire timing_t     wr_timing,
    output logic             chip_select_n,
    output logic             output_enable_n,
    output logic             write_strobe_n,
    output logic             address_valid_n,
    output logic [1:0]       byte_lane_n,
    output logic [25:0]      mem_upper_addr,
    output logic [15:0]      mem_ad_out,
    output logic             mem_ad_oe,
    input  wire logic [15:0] mem_ad_in,
    input  wire logic        mem_wait_n
);
    phase_t      state_q;
    mem_req_t    req_q;
    timing_t     tim;
    logic        wide_q;
    logic [1:0]  beat_q;
    logic [1:0]  beats_q;
    logic [25:0] addr_q;
    logic [31:0] rdata_q;
    logic [15:0] din_s1_q;
    logic [15:0] din_s2_q;
    logic        wait_s1_q;
    logic        wait_s2_q;
    logic        ph_load;
    logic [7:0]  ph_value;
    logic        ph_hold;
    logic        ph_last;
    logic        req_ok;
    logic        is_16;
    logic [1:0]  nbeats;
    logic [7:0]  wbyte;
    logic [15:0] whalf;
    logic        err_q;
    logic        cap1_q;
    logic        cap2_q;
    logic [1:0]  cbeat1_q;
    logic [1:0]  cbeat2_q;
    logic [31:0] rd_merge;

    // all assertions below sample on the bus clock, off during reset
    default clocking cb_chk @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // pin inputs pass two flip-flops
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            din_s1_q  <= 16'h0000;
            din_s2_q  <= 16'h0000;
            wait_s1_q <= 1'b1;
            wait_s2_q <= 1'b1;
        end else begin
            din_s1_q  <= mem_ad_in;
            din_s2_q  <= din_s1_q;
            wait_s1_q <= mem_wait_n;
            wait_s2_q <= wait_s1_q;
        end
    end

    // memory width from configuration, 8 or 16 bits
    assign is_16 = (cfg.region_bus_width == `WIDTH_CODE_16); // [RULE_03] [RULE_19]
    // read and write timings kept apart
    assign tim = req_q.write ? wr_timing : rd_timing; // [RULE_17]

    // request check: region zero, enabled, writes allowed
    always_comb begin
        req_ok = cfg.bank_en &&
                 (req.addr[`REGION_MSB:`REGION_LSB] == `REGION_ZERO); // [RULE_08] [RULE_09]
        if (req.write && !cfg.region_write_enable) begin
            req_ok = 1'b0; // [RULE_18]
        end
        // byte write to 16-bit nor has no byte select
        if (req.write && is_16 && req.size == `SIZE_BYTE &&
            cfg.mem_type == `TYPE_NOR) begin
            req_ok = 1'b0; // [RULE_06]
        end
    end

    // number of memory cycles per access, less one
    always_comb begin
        nbeats = 2'h0; // one cycle when widths match [RULE_04]
        if (req.size == `SIZE_WORD) begin
            nbeats = is_16 ? 2'h1 : 2'h3; // [RULE_05]
        end else if (req.size == `SIZE_HALF && !is_16) begin
            nbeats = 2'h1; // [RULE_05]
        end
    end

    // phase counter load values, each n+1 cycles
    always_comb begin
        ph_load  = 1'b0;
        ph_value = 8'h00;
        case (state_q)
            ST_IDLE: begin
                ph_load  = req_valid && req_ok;
                ph_value = {4'h0, (req.write ? wr_timing.addr_setup_time
                                             : rd_timing.addr_setup_time)};
            end
            ST_ADDR_SETUP_TIME: begin
                ph_load  = ph_last;
                ph_value = cfg.muxed ? {4'h0, tim.addr_hold_time}
                                     : tim.data_setup_time;
            end
            ST_ADDR_HOLD_TIME: begin
                ph_load  = ph_last;
                ph_value = tim.data_setup_time;
            end
            ST_DATA_SETUP_TIME: begin
                ph_load  = ph_last;
                ph_value = {4'h0, tim.bus_turnaround_time};
            end
            ST_TURN: begin
                ph_load  = ph_last && beat_q != beats_q;
                ph_value = {4'h0, tim.addr_setup_time};
            end
            default: begin
                ph_load  = 1'b0;
                ph_value = 8'h00;
            end
        endcase
    end
    // data setup stretched while the memory holds wait active
    assign ph_hold = (state_q == ST_DATA_SETUP_TIME) && cfg.async_wait_enable &&
                     !wait_s2_q; // [RULE_21]

    // eight bits reach the longest data setup [RULE_15]
    phase_counter #(.W(8)) u_phase (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .load    (ph_load),
        .value   (ph_value),
        .hold    (ph_hold),
        .last    (ph_last)
    );

    // phase sequencer, all on the bus clock [RULE_01]
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: if (req_valid) state_q <= req_ok ? ST_ADDR_SETUP_TIME : ST_DONE;
                ST_ADDR_SETUP_TIME: if (ph_last) state_q <= cfg.muxed ? ST_ADDR_HOLD_TIME : ST_DATA_SETUP_TIME; // [RULE_16]
                ST_ADDR_HOLD_TIME: if (ph_last) state_q <= ST_DATA_SETUP_TIME; // [RULE_16]
                ST_DATA_SETUP_TIME: if (ph_last) state_q <= ST_TURN; // [RULE_16]
                ST_TURN: if (ph_last) state_q <= (beat_q == beats_q) ? ST_DONE
                                                                     : ST_ADDR_SETUP_TIME;
                ST_DONE: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // request capture and beat addressing
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            req_q   <= '0;
            beat_q  <= 2'h0;
            beats_q <= 2'h0;
            wide_q  <= 1'b0;
            addr_q  <= 26'h0;
        end else if (state_q == ST_IDLE && req_valid) begin
            req_q   <= req;
            beat_q  <= 2'h0;
            beats_q <= nbeats;
            wide_q  <= is_16;
            // 8-bit keeps byte address, 16-bit uses half-word address
            addr_q  <= is_16 ? {1'b0, req.addr[25:1]} // [RULE_11]
                             : req.addr[25:0];        // [RULE_10]
        end else if (state_q == ST_TURN && ph_last && beat_q != beats_q) begin
            beat_q <= beat_q + 2'h1;
            addr_q <= addr_q + 26'h1; // ascending addresses [RULE_22]
        end
    end

    // write data of the current beat
    always_comb begin
        wbyte = req_q.wdata[8*beat_q +: 8];
        whalf = wide_q ? req_q.wdata[16*beat_q[0] +: 16] : {8'h00, wbyte};
        if (wide_q && req_q.size == `SIZE_BYTE) begin
            whalf = {req_q.wdata[8*req_q.addr[1:0] +: 8],
                     req_q.wdata[8*req_q.addr[1:0] +: 8]};
        end
    end

    // read beat leaves the pin synchroniser two edges after data setup
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cap1_q   <= 1'b0;
            cap2_q   <= 1'b0;
            cbeat1_q <= 2'h0;
            cbeat2_q <= 2'h0;
        end else begin
            cap1_q   <= (state_q == ST_DATA_SETUP_TIME) && ph_last && !req_q.write;
            cap2_q   <= cap1_q;
            cbeat1_q <= beat_q;
            cbeat2_q <= cbeat1_q;
        end
    end

    // little-endian merge of the late beat, so short turnarounds still work
    always_comb begin
        rd_merge = rdata_q;
        if (cap2_q && wide_q) begin
            rd_merge[16*cbeat2_q[0] +: 16] = din_s2_q; // [RULE_22]
        end else if (cap2_q) begin
            rd_merge[8*cbeat2_q +: 8] = din_s2_q[7:0]; // [RULE_22]
        end
    end

    // assembled read word, cleared as each request is taken
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0;
        end else if (state_q == ST_IDLE && req_valid) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= rd_merge;
        end
    end

    // memory pins, all registered on rising clock edges
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            chip_select_n   <= 1'b1;
            output_enable_n <= 1'b1;
            write_strobe_n  <= 1'b1;
            address_valid_n <= 1'b1;
            byte_lane_n     <= 2'h3;
            mem_upper_addr  <= 26'h0;
            mem_ad_out      <= 16'h0000;
            mem_ad_oe       <= 1'b0;
        end else begin
            chip_select_n   <= !(state_q == ST_ADDR_SETUP_TIME || state_q == ST_ADDR_HOLD_TIME ||
                                 state_q == ST_DATA_SETUP_TIME); // [RULE_12] [RULE_02]
            output_enable_n <= !(state_q == ST_DATA_SETUP_TIME && !req_q.write);
            write_strobe_n  <= !(state_q == ST_DATA_SETUP_TIME && req_q.write);
            address_valid_n <= !(state_q == ST_ADDR_SETUP_TIME && cfg.muxed); // [RULE_13]
            mem_upper_addr  <= addr_q; // [RULE_14]
            byte_lane_n     <= 2'h0;
            if (wide_q && req_q.size == `SIZE_BYTE && req_q.write) begin
                byte_lane_n <= req_q.addr[0] ? 2'h1 : 2'h2; // [RULE_07]
            end
            // muxed: low address on shared bus before data
            if (cfg.muxed && (state_q == ST_ADDR_SETUP_TIME || state_q == ST_ADDR_HOLD_TIME)) begin
                mem_ad_out <= addr_q[15:0]; // [RULE_13]
                mem_ad_oe  <= 1'b1;
            end else if (req_q.write && state_q == ST_DATA_SETUP_TIME) begin
                mem_ad_out <= whalf;
                mem_ad_oe  <= 1'b1;
            end else begin
                mem_ad_out <= 16'h0000;
                mem_ad_oe  <= 1'b0; // released for read and turnaround [RULE_23]
            end
        end
    end

    // bus handshake and response
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_error <= 1'b0;
            rsp_rdata <= 32'h0;
        end else begin
            req_ready <= (state_q == ST_IDLE) && req_valid;
            rsp_valid <= (state_q == ST_DONE); // only after the last cycle [RULE_22]
            rsp_error <= (state_q == ST_DONE) && err_q;
            rsp_rdata <= (state_q == ST_DONE) ? rd_merge : 32'h0;
        end
    end

    // error marker for refused requests
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            err_q <= 1'b0;
        end else if (state_q == ST_IDLE && req_valid) begin
            err_q <= !req_ok; // [RULE_18] [RULE_06] [RULE_09]
        end
    end

    // refused access goes to done with memory strobes off
    a_refused_no_strobe: assert property ( // [RULE_18]
        (state_q == ST_IDLE && req_valid && !req_ok) |=>
        (state_q == ST_DONE && write_strobe_n && chip_select_n) ##1
        (write_strobe_n && chip_select_n))
        else $error("refused access strobed memory");
    // chip select high one edge after idle
    a_cs_idle_high: assert property ( // [RULE_12]
        $past(state_q) == ST_IDLE |-> chip_select_n)
        else $error("chip select active while idle");
    // strobes never both active
    a_oe_we_excl: assert property ( // [RULE_16]
        !(!output_enable_n && !write_strobe_n))
        else $error("read and write strobes together");
    // address valid only in muxed mode
    a_adv_muxed: assert property ( // [RULE_13]
        !address_valid_n |-> cfg.muxed)
        else $error("address valid outside muxed mode");
    // response follows done state
    a_rsp_after_done: assert property ( // [RULE_22]
        rsp_valid |-> $past(state_q) == ST_DONE)
        else $error("response before last cycle");
    // wait holds data setup
    a_wait_stretch: assert property ( // [RULE_21]
        (state_q == ST_DATA_SETUP_TIME && ph_hold) |=> state_q == ST_DATA_SETUP_TIME)
        else $error("data setup not stretched by wait");
    // bus released during reads
    a_read_release: assert property ( // [RULE_23]
        !output_enable_n |-> !mem_ad_oe)
        else $error("bus driven during read");
    // byte write strobes a single lane
    a_byte_lane: assert property ( // [RULE_07]
        (!write_strobe_n && wide_q && req_q.size == `SIZE_BYTE)
        |-> byte_lane_n == (req_q.addr[0] ? 2'h1 : 2'h2))
        else $error("wrong byte lane on byte write");
endmodule // async_static_mem_ctrl
`default_nettype wire

// ===== core/static_mem_regs.svh
// constants and summary for the async static memory controller
// Summary of operation
// [RULE_01] everything runs from the bus clock, which times every memory phase
// [RULE_02] memory-facing outputs change only on rising bus clock edges
// [RULE_03] memory data bus is configurable as 8 or 16 bits
// [RULE_04] access equal to memory width takes one memory cycle, unconverted
// [RULE_05] wider access splits into back-to-back cycles of memory width
// [RULE_06] narrow reads always served; narrow writes need byte selection
// [RULE_07] byte writes to 16-bit sram/psram strobe only addressed byte lane
// [RULE_08] bank holds four 64 Mbyte regions; only the first exists
// [RULE_09] address bits 27:26 pick the region; only region zero is served
// [RULE_10] 8-bit memory takes byte address bits 25:0 unchanged
// [RULE_11] 16-bit memory takes address bits 25:1 as half-word address
// [RULE_12] region zero has its own chip select; other pins are shared
// [RULE_13] muxed mode: low address and data share bus, address valid strobe
// [RULE_14] region serves nor, psram, sram and rom chosen by configuration
// [RULE_15] turnaround 1-16, data setup 2-256, hold 2-16, setup 1-16 cycles
// [RULE_16] muxed model runs setup, hold, data setup, turnaround phases
// [RULE_17] read and write timings come from separate settings
// [RULE_18] writes with write enable clear are blocked and answer error
// [RULE_19] width code 00 is 8 bits, 01 is 16 bits, others reserved
// [RULE_20] each timing field n gives n+1 cycles
// [RULE_21] asynchronous wait stretches data setup while wait is active
// [RULE_22] split cycles use ascending addresses; data assembled little-endian
// [RULE_23] memory drives read data only under output and chip enable
`ifndef STATIC_MEM_REGS_SVH
`define STATIC_MEM_REGS_SVH
`define WIDTH_CODE_8      2'h0
`define WIDTH_CODE_16     2'h1
`define TYPE_SRAM         2'h0
`define TYPE_PSRAM        2'h1
`define TYPE_NOR          2'h2
`define REGION_ZERO       2'h0
`define REGION_MSB        27
`define REGION_LSB        26
`define SIZE_BYTE         3'h0
`define SIZE_HALF         3'h1
`define SIZE_WORD         3'h2
`define TIMING_ADDR_SETUP_TIME_LSB   0
`define TIMING_ADDR_HOLD_TIME_LSB   4
`define TIMING_DATA_SETUP_TIME_LSB   8
`define TIMING_BLAT_LSB   16
`endif

// ===== core/static_mem_pkg.sv
// types shared by the async static memory controller
package static_mem_pkg;
    // one bus request
    typedef struct packed {
        logic [31:0] addr;
        logic [2:0]  size;
        logic        write;
        logic [31:0] wdata;
    } mem_req_t;
    // region configuration
    typedef struct packed {
        logic       bank_en;
        logic       muxed;
        logic [1:0] mem_type;
        logic [1:0] region_bus_width;
        logic       region_write_enable;
        logic       async_wait_enable;
    } region_cfg_t;
    // phase timings as packed fields
    typedef struct packed {
        logic [3:0] bus_turnaround_time;
        logic [7:0] data_setup_time;
        logic [3:0] addr_hold_time;
        logic [3:0] addr_setup_time;
    } timing_t;
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_ADDR_SETUP_TIME  = 6'h02,
        ST_ADDR_HOLD_TIME  = 6'h04,
        ST_DATA_SETUP_TIME  = 6'h08,
        ST_TURN  = 6'h10,
        ST_DONE  = 6'h20
    } phase_t;
endpackage : static_mem_pkg

// ===== core/phase_counter.sv
// loadable down counter timing one memory phase
`timescale 1ns/1ps
`default_nettype none
module phase_counter #(
    parameter int W = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    input  wire logic         hold,
    output var  logic         last
);
    logic [W-1:0] cnt_q;
    // field value n gives n+1 cycles, so count down to zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= value; // [RULE_20]
        end else if (!hold && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
    assign last = (cnt_q == '0) && !hold; // load is fed back from last
endmodule // phase_counter
`default_nettype wire

// ===== tb/static_mem_model.sv
// behavioural external static memory for the controller bench
`timescale 1ns/1ps
`default_nettype none
module static_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        chip_select_n,
    input  wire logic        output_enable_n,
    input  wire logic        write_strobe_n,
    input  wire logic        address_valid_n,
    input  wire logic [1:0]  byte_lane_n,
    input  wire logic [25:0] mem_upper_addr,
    input  wire logic [15:0] mem_ad_out,
    input  wire logic        mem_ad_oe,
    input  wire logic        muxed,
    input  wire logic        bus16,
    input  wire logic [3:0]  wait_len,
    output logic      [15:0] mem_ad_in,
    output logic             mem_wait_n
);
    logic [15:0] mem [0:255];
    logic [15:0] alat_q = 16'h0;
    logic [15:0] last_q = 16'h0;
    logic [3:0]  wcnt_q = 4'h0;
    logic [7:0]  idx;
    logic        drive;
    initial for (int i = 0; i < 256; i++) mem[i] = 16'h0;
    // word index from latched or direct address
    assign idx = muxed ? alat_q[7:0] : mem_upper_addr[7:0];
    // read data only under chip select and output enable
    assign drive = !chip_select_n && !output_enable_n;
    // wire level: controller, memory, else inverse of last value
    assign mem_ad_in = mem_ad_oe ? mem_ad_out :
                       drive ? (bus16 ? mem[idx] :
                                {~mem[idx][7:0], mem[idx][7:0]}) : ~last_q;
    // wait held low for wait_len cycles after select
    assign mem_wait_n = !(wcnt_q != 4'h0 && !chip_select_n);
    // address latch, lane writes and wait counter
    always @(posedge ref_clk) begin
        last_q <= mem_ad_in;
        if (!address_valid_n) alat_q <= mem_ad_out;
        if (!chip_select_n && !write_strobe_n) begin
            if (!bus16 || !byte_lane_n[0]) mem[idx][7:0] <= mem_ad_out[7:0];
            if (bus16 && !byte_lane_n[1]) mem[idx][15:8] <= mem_ad_out[15:8];
        end
        wcnt_q <= chip_select_n ? wait_len : wcnt_q - (wcnt_q != 4'h0);
    end
endmodule // static_mem_model
`default_nettype wire

// ===== tb/async_static_mem_ctrl_bench.sv
// self-checking bench for the async static memory controller
`timescale 1ns/1ps
`default_nettype none
module async_static_mem_ctrl_bench
    import static_mem_pkg::*;
;
    logic ref_clk, rst_n, req_valid, req_ready, rsp_valid, rsp_error;
    logic chip_select_n, output_enable_n, write_strobe_n, address_valid_n;
    logic mem_ad_oe, mem_wait_n;
    logic [1:0]  byte_lane_n;
    logic [25:0] mem_upper_addr;
    logic [15:0] mem_ad_out, mem_ad_in;
    logic [31:0] rsp_rdata, rd_v;
    logic [3:0]  wait_len;
    mem_req_t    req;
    region_cfg_t cfg;
    timing_t     rd_timing, wr_timing;
    logic        er_v, cs_d = 1, oe_d = 1, we_d = 1;
    logic [1:0]  lanes = 2'h3;
    int          n_mismatch = 0, check_count = 0;
    int          cs_falls = 0, oe_len = 0, we_len = 0, falls0;
    async_static_mem_ctrl dut (.ref_clk, .rst_n, .req_valid, .req, .req_ready,
        .rsp_valid, .rsp_error, .rsp_rdata, .cfg, .rd_timing, .wr_timing,
        .chip_select_n, .output_enable_n, .write_strobe_n, .address_valid_n,
        .byte_lane_n, .mem_upper_addr, .mem_ad_out, .mem_ad_oe, .mem_ad_in,
        .mem_wait_n);
    static_mem_model mdl (.muxed(cfg.muxed), .bus16(cfg.region_bus_width[0]),
        .ref_clk, .chip_select_n, .output_enable_n, .write_strobe_n,
        .address_valid_n, .byte_lane_n, .mem_upper_addr, .mem_ad_out,
        .mem_ad_oe, .wait_len, .mem_ad_in, .mem_wait_n);
    initial begin
        ref_clk = 0;
        forever #4 ref_clk = ~ref_clk;
    end
    // pin watcher: select count, strobe lengths, lanes under strobe
    always @(posedge ref_clk) begin
        cs_d <= chip_select_n;
        oe_d <= output_enable_n;
        we_d <= write_strobe_n;
        if (cs_d && !chip_select_n) cs_falls <= cs_falls + 1;
        if (!output_enable_n) oe_len <= oe_d ? 1 : oe_len + 1;
        if (!write_strobe_n) we_len <= we_d ? 1 : we_len + 1;
        if (!write_strobe_n) lanes <= byte_lane_n;
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic waitfor(input string nm, ref logic s);
        int i;
        for (i = 0; i < 3000; i++) begin
            @(posedge ref_clk);
            if (s === 1'b1) break;
        end
        if (i == 3000) begin
            chk(nm, 1, 0);
            final_report();
        end
    endtask
    // one bus access held until taken, then answer collected
    task automatic xfer(input logic [31:0] a, input logic [2:0] s,
                        input logic w, input logic [31:0] d);
        req_valid <= 1'b1;
        req <= '{addr: a, size: s, write: w, wdata: d};
        waitfor("req_ready", req_ready);
        req_valid <= 1'b0;
        waitfor("rsp_valid", rsp_valid);
        rd_v = rsp_rdata;
        er_v = rsp_error;
        @(posedge ref_clk);
    endtask
    task automatic cfg_set(input logic m, input logic [1:0] t, w,
                           input logic we, aw);
        cfg <= '{1'b1, m, t, w, we, aw};
        @(posedge ref_clk);
    endtask
    initial begin
        rst_n = 0;
        req_valid = 0;
        req = '0;
        wait_len = 4'h0;
        cfg = '{1'b1, 1'b0, 2'h0, 2'h1, 1'b1, 1'b0};
        rd_timing = '{4'h1, 8'h02, 4'h1, 4'h1};
        wr_timing = '{4'h0, 8'h05, 4'h1, 4'h2};
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        // 16-bit sram: split word, half-word addressing
        xfer(32'h10, 3'h2, 1, 32'h44332211);
        chk("lo_half", 16'h2211, mdl.mem[8]);
        chk("hi_half", 16'h4433, mdl.mem[9]);
        xfer(32'h10, 3'h2, 0, 0);
        chk("word_rd", 32'h44332211, rd_v);
        $display("test split16 done");
        // byte lanes and independent phase lengths
        xfer(32'h21, 3'h0, 1, 32'haaaaaaaa);
        chk("lane_hi", 2'h1, lanes);
        chk("we_len", 6, we_len);
        xfer(32'h20, 3'h0, 1, 32'h55555555);
        chk("lane_lo", 2'h2, lanes);
        xfer(32'h20, 3'h1, 0, 0);
        chk("half_rd", 16'haa55, rd_v[15:0]);
        chk("oe_len", 3, oe_len);
        $display("test lanes done");
        // 8-bit memory: four ascending byte cycles
        cfg_set(1'b0, 2'h0, 2'h0, 1'b1, 1'b0);
        xfer(32'h40, 3'h2, 1, 32'h88776655);
        for (int i = 0; i < 4; i++)
            chk("byte8", 8'h55 + 8'h11 * i, mdl.mem[64 + i][7:0]);
        xfer(32'h40, 3'h2, 0, 0);
        chk("rd8", 32'h88776655, rd_v);
        $display("test bus8 done");
        // muxed nor flash: address on shared bus, byte write refused
        cfg_set(1'b1, 2'h2, 2'h1, 1'b1, 1'b0);
        xfer(32'h80, 3'h1, 1, 32'h0000beef);
        chk("nor_wr", 16'hbeef, mdl.mem[64]);
        xfer(32'h80, 3'h1, 0, 0);
        chk("nor_rd", 16'hbeef, rd_v[15:0]);
        falls0 = cs_falls;
        xfer(32'h80, 3'h0, 1, 32'h11111111);
        chk("nor_berr", 1, er_v);
        chk("nor_keep", 16'hbeef, mdl.mem[64]);
        xfer(32'h81, 3'h0, 0, 0);
        chk("nor_brd", 0, er_v);
        $display("test muxed done");
        // refused accesses: no memory cycle, error answer
        cfg_set(1'b0, 2'h0, 2'h1, 1'b1, 1'b0);
        falls0 = cs_falls;
        xfer(32'h0400_0010, 3'h1, 0, 0);
        chk("region1", 1, er_v);
        xfer(32'h0c00_0010, 3'h1, 1, 0);
        chk("region3", 1, er_v);
        cfg_set(1'b0, 2'h0, 2'h1, 1'b0, 1'b0);
        xfer(32'h10, 3'h1, 1, 32'h9999);
        chk("wr_dis", 1, er_v);
        cfg <= '{1'b0, 1'b0, 2'h0, 2'h1, 1'b1, 1'b0};
        xfer(32'h10, 3'h1, 0, 0);
        chk("bank_off", 1, er_v);
        chk("no_cycle", falls0, cs_falls);
        chk("kept", 16'h2211, mdl.mem[8]);
        $display("test refuse done");
        // asynchronous wait stretches data setup
        cfg_set(1'b0, 2'h1, 2'h1, 1'b1, 1'b1);
        rd_timing <= '{4'h1, 8'h0f, 4'h1, 4'h1};
        wait_len <= 4'h6;
        @(posedge ref_clk);
        xfer(32'h12, 3'h1, 0, 0);
        chk("wait_rd", 16'h4433, rd_v[15:0]);
        chk("stretch", 1, oe_len > 16);
        $display("test wait done");
        final_report();
    end
endmodule // async_static_mem_ctrl_bench
`default_nettype wire
